/* logic/msi_pkg.sv */
// Shared constants, codes and state records for the motion status register bank
`default_nettype none
package msi_pkg;
    // Register offsets on the serial link
    localparam logic [7:0] REG_Y = 8'h01;
    localparam logic [7:0] REG_Z = 8'h02;
    localparam logic [7:0] REG_TILT = 8'h03;
    localparam logic [7:0] REG_RATE = 8'h04;
    localparam logic [7:0] REG_SLEEP = 8'h05;
    localparam logic [7:0] REG_INTERRUPT_SETUP = 8'h06;
    localparam logic [7:0] RESET_BYTE = 8'h00;
    // Interrupt setup field positions
    localparam int FACE_EN_BIT = 0;
    localparam int PORT_EN_BIT = 1;
    localparam int TAP_EN_BIT = 2;
    localparam int SLEEP_EN_BIT = 3;
    localparam int EVERY_EN_BIT = 4;
    localparam int SHAKE_Z_BIT = 5;
    localparam int SHAKE_Y_BIT = 6;
    localparam int SHAKE_X_BIT = 7;
    // Orientation codes
    localparam logic [1:0] FACE_UNKNOWN = 2'h0;
    localparam logic [1:0] FACE_FRONT = 2'h1;
    localparam logic [1:0] FACE_BACK = 2'h2;
    localparam logic [2:0] PORT_UNKNOWN = 3'h0;
    localparam logic [2:0] PORT_LEFT = 3'h1;
    localparam logic [2:0] PORT_RIGHT = 3'h2;
    localparam logic [2:0] PORT_DOWN = 3'h5;
    localparam logic [2:0] PORT_UP = 3'h6;
    // Shake bounds in counts, about 1.3 g at 21.3 counts per g
    localparam logic signed [5:0] SHAKE_HI = 6'sh1B;
    localparam logic signed [5:0] SHAKE_LO = -6'sh1B;
    localparam logic [2:0] LAST_BIT = 3'h7;
    localparam logic [7:0] SLEEP_ZERO = 8'h00;

    // Link engine states, Gray along address, data and acknowledge
    typedef enum logic [2:0] {
        LNK_IDLE = 3'h0,
        LNK_ADDR = 3'h1,
        LNK_ADDR_ACK = 3'h3,
        LNK_WR_BYTE = 3'h2,
        LNK_WR_ACK = 3'h6,
        LNK_RD_BYTE = 3'h7,
        LNK_RD_ACK = 3'h5
    } msi_link_state_t;

    // Sensor measurement bundle
    typedef struct packed {
        logic signed [5:0] x;
        logic signed [5:0] y;
        logic signed [5:0] z;
        logic [1:0] face;
        logic [2:0] port;
        logic tap;
    } msi_meas_t;

    // State on the system clock
    typedef struct packed {
        logic [5:0] y;
        logic [5:0] z;
        logic alert;
        logic shake;
        logic tap;
        logic [2:0] port;
        logic [1:0] face;
        logic [7:0] sleepLimit;
        logic [7:0] sleepCount;
        logic [7:0] intSetup;
        logic inWake;
        logic prevActive;
        logic firstSample;
        logic pendValid;
        logic pendCollide;
        logic pendMeasured;
        logic pendShake;
        msi_meas_t pend;
        logic irqActive;
        logic irqPin;
        logic activeRateInUse;
        logic wakeRateInUse;
        logic [2:0] sampleRateCode;
        logic busyS1;
        logic busyS2;
        logic [2:0] wrSync;
        logic [2:0] relSync;
        logic [2:0] tiltSync;
    } msi_core_t;

    // State on the link clock
    typedef struct packed {
        logic rstS1;
        logic rstS2;
        msi_link_state_t state;
        logic [2:0] cnt;
        logic [7:0] shift;
        logic [7:0] ptr;
        logic [7:0] rdAddr;
        logic rw;
        logic first;
        logic readBusy;
        logic wrTog;
        logic [7:0] wrAddr;
        logic [7:0] wrData;
        logic relTog;
        logic tiltTog;
        logic startCopy;
        logic sdaOeN;
        logic sdaOut;
    } msi_link_t;
endpackage
`default_nettype wire

/* logic/msi_status_regs.sv */
// Motion sensor status, sleep and interrupt register bank behind a serial slave
`default_nettype none
module msi_status_regs #(
    parameter logic [6:0] DEV_ADDR = 7'h2A // Arbitrary slave address
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic sclClk,
    input wire logic sdaIn,
    output logic sdaOut,
    output logic sdaOeN,
    output logic irqPin,
    input wire logic modeActive,
    input wire logic test_mode_bit,
    input wire logic irq_polarity_select,
    input wire logic autoSleepEnable,
    input wire logic autoWakeEnable,
    input wire logic [2:0] active_rate_field,
    input wire logic [1:0] wake_rate_field,
    input wire logic sleepTick,
    input wire logic sampleStrobe,
    input wire msi_pkg::msi_meas_t meas,
    output logic active_rate_in_use,
    output logic wake_rate_in_use,
    output logic [2:0] sampleRateCode
);
    msi_pkg::msi_core_t c;
    msi_pkg::msi_core_t next_c;
    msi_pkg::msi_link_t l;
    msi_pkg::msi_link_t next_l;
    logic startTog;
    logic startSeen;
    logic wrEvt;
    logic relEvt;
    logic tiltRdEvt;
    logic [7:0] rdByte;

    // Orientation code cleanup, reserved encodings read as unknown
    function automatic logic [1:0] cleanFace(input logic [1:0] f);
        cleanFace = (f == 2'h3) ? msi_pkg::FACE_UNKNOWN : f;
    endfunction

    function automatic logic [2:0] cleanPort(input logic [2:0] p);
        case (p)
            msi_pkg::PORT_LEFT, msi_pkg::PORT_RIGHT, msi_pkg::PORT_DOWN, msi_pkg::PORT_UP: begin
                cleanPort = p;
            end
            default: begin
                cleanPort = msi_pkg::PORT_UNKNOWN;
            end
        endcase
    endfunction

    // Shake test on one axis against the symmetric bound
    function automatic logic overLimit(input logic signed [5:0] s);
        overLimit = (s > msi_pkg::SHAKE_HI) || (s < msi_pkg::SHAKE_LO);
    endfunction

    // Register image seen by the link; y, z, alert, tap, port and face stay stable while a read frame is open
    always_comb begin
        case (l.ptr)
            msi_pkg::REG_Y: rdByte = {1'b0, c.alert, c.y};
            msi_pkg::REG_Z: rdByte = {1'b0, c.alert, c.z};
            msi_pkg::REG_TILT: rdByte = {c.shake, c.alert, c.tap, c.port, c.face};
            msi_pkg::REG_RATE: rdByte = {6'h00, c.wakeRateInUse, c.activeRateInUse};
            msi_pkg::REG_SLEEP: rdByte = c.sleepLimit;
            msi_pkg::REG_INTERRUPT_SETUP: rdByte = c.intSetup;
            default: rdByte = msi_pkg::RESET_BYTE;
        endcase
    end

    // Start condition: data falls while the link clock is high
    always_ff @(negedge sdaIn or posedge sys_rst) begin
        if (sys_rst) begin
            startTog <= 1'b0;
        end else if (sclClk) begin
            startTog <= ~startTog;
        end
    end

    // The toggle settles half a high phase before the falling edge that reads it
    assign startSeen = startTog != l.startCopy;
    // Events handed over from the link side, edge of the second sync flop
    assign wrEvt = c.wrSync[1] != c.wrSync[2];
    assign relEvt = c.relSync[1] != c.relSync[2];
    assign tiltRdEvt = c.tiltSync[1] != c.tiltSync[2];

    // Link engine next state; sampled and driven on the falling link edge
    always_comb begin
        next_l = l;
        next_l.rstS1 = sys_rst;
        next_l.rstS2 = l.rstS1;
        if (l.rstS2) begin
            next_l.state = msi_pkg::LNK_IDLE;
            next_l.cnt = 3'h0;
            next_l.shift = msi_pkg::RESET_BYTE;
            next_l.ptr = msi_pkg::RESET_BYTE;
            next_l.rdAddr = msi_pkg::RESET_BYTE;
            next_l.rw = 1'b0;
            next_l.first = 1'b0;
            next_l.readBusy = 1'b0;
            next_l.wrTog = 1'b0;
            next_l.wrAddr = msi_pkg::RESET_BYTE;
            next_l.wrData = msi_pkg::RESET_BYTE;
            next_l.relTog = 1'b0;
            next_l.tiltTog = 1'b0;
            next_l.startCopy = startTog;
            next_l.sdaOeN = 1'b1;
            next_l.sdaOut = 1'b0;
        end else if (startSeen) begin
            // Any start, repeated or not, restarts address reception
            next_l.startCopy = startTog;
            next_l.state = msi_pkg::LNK_ADDR;
            next_l.cnt = 3'h0;
            next_l.sdaOeN = 1'b1;
            next_l.readBusy = 1'b1; // Freeze the image until the frame kind is known
        end else begin
            case (l.state)
                msi_pkg::LNK_ADDR: begin
                    next_l.shift = {l.shift[6:0], sdaIn};
                    next_l.cnt = l.cnt + 3'h1;
                    if (l.cnt == msi_pkg::LAST_BIT) begin
                        if (l.shift[6:0] == DEV_ADDR) begin
                            next_l.state = msi_pkg::LNK_ADDR_ACK;
                            next_l.sdaOeN = 1'b0; // Acknowledge by pulling low
                            next_l.rw = sdaIn;
                            next_l.readBusy = sdaIn;
                            next_l.relTog = ~l.relTog;
                        end else begin
                            next_l.state = msi_pkg::LNK_IDLE;
                            next_l.readBusy = 1'b0;
                        end
                    end
                end
                msi_pkg::LNK_ADDR_ACK: begin
                    next_l.cnt = 3'h0;
                    if (l.rw) begin
                        next_l.shift = rdByte;
                        next_l.sdaOeN = rdByte[7];
                        next_l.rdAddr = l.ptr;
                        next_l.ptr = l.ptr + 8'h01;
                        next_l.state = msi_pkg::LNK_RD_BYTE;
                    end else begin
                        next_l.sdaOeN = 1'b1;
                        next_l.first = 1'b1;
                        next_l.state = msi_pkg::LNK_WR_BYTE;
                    end
                end
                msi_pkg::LNK_WR_BYTE: begin
                    next_l.shift = {l.shift[6:0], sdaIn};
                    next_l.cnt = l.cnt + 3'h1;
                    if (l.cnt == msi_pkg::LAST_BIT) begin
                        next_l.sdaOeN = 1'b0;
                        next_l.state = msi_pkg::LNK_WR_ACK;
                        if (l.first) begin
                            next_l.ptr = {l.shift[6:0], sdaIn};
                        end else begin
                            // Address and data stay put for nine link periods
                            next_l.wrAddr = l.ptr;
                            next_l.wrData = {l.shift[6:0], sdaIn};
                            next_l.wrTog = ~l.wrTog;
                            next_l.ptr = l.ptr + 8'h01;
                        end
                    end
                end
                msi_pkg::LNK_WR_ACK: begin
                    next_l.sdaOeN = 1'b1;
                    next_l.first = 1'b0;
                    next_l.cnt = 3'h0;
                    next_l.state = msi_pkg::LNK_WR_BYTE;
                end
                msi_pkg::LNK_RD_BYTE: begin
                    if (l.cnt == msi_pkg::LAST_BIT) begin
                        next_l.sdaOeN = 1'b1;
                        next_l.state = msi_pkg::LNK_RD_ACK;
                    end else begin
                        next_l.shift = {l.shift[6:0], 1'b0};
                        next_l.sdaOeN = l.shift[6];
                        next_l.cnt = l.cnt + 3'h1;
                    end
                end
                msi_pkg::LNK_RD_ACK: begin
                    if (l.rdAddr == msi_pkg::REG_TILT) begin
                        next_l.tiltTog = ~l.tiltTog;
                    end
                    next_l.cnt = 3'h0;
                    if (!sdaIn) begin
                        next_l.shift = rdByte;
                        next_l.sdaOeN = rdByte[7];
                        next_l.rdAddr = l.ptr;
                        next_l.ptr = l.ptr + 8'h01;
                        next_l.state = msi_pkg::LNK_RD_BYTE;
                    end else begin
                        next_l.state = msi_pkg::LNK_IDLE;
                        next_l.readBusy = 1'b0;
                    end
                end
                default: begin
                    next_l.state = msi_pkg::LNK_IDLE;
                    next_l.sdaOeN = 1'b1;
                end
            endcase
        end
    end

    // Link register; falling edge keeps data changes inside the low phase
    always_ff @(negedge sclClk) begin
        l <= next_l;
    end

    // Core next state on the system clock
    always_comb begin
        logic testWrite;
        logic measured;
        logic apply;
        logic faceChg;
        logic portChg;
        logic activity;
        logic sleepExit;
        logic irqEvt;
        logic [1:0] newFace;
        logic [2:0] newPort;
        testWrite = 1'b0;
        measured = 1'b0;
        apply = 1'b0;
        faceChg = 1'b0;
        portChg = 1'b0;
        activity = 1'b0;
        sleepExit = 1'b0;
        irqEvt = 1'b0;
        newFace = c.face;
        newPort = c.port;
        next_c = c;
        next_c.busyS1 = l.readBusy;
        next_c.busyS2 = c.busyS1;
        next_c.wrSync = {c.wrSync[1:0], l.wrTog};
        next_c.relSync = {c.relSync[1:0], l.relTog};
        next_c.tiltSync = {c.tiltSync[1:0], l.tiltTog};
        next_c.prevActive = modeActive;
        // Host writes; configuration writes assume standby
        if (wrEvt) begin
            case (l.wrAddr)
                msi_pkg::REG_SLEEP: begin
                    next_c.sleepLimit = l.wrData;
                    next_c.sleepCount = msi_pkg::SLEEP_ZERO;
                end
                msi_pkg::REG_INTERRUPT_SETUP: next_c.intSetup = l.wrData;
                msi_pkg::REG_Y, msi_pkg::REG_Z: testWrite = test_mode_bit;
                default: testWrite = 1'b0;
            endcase
        end
        measured = modeActive && !test_mode_bit && sampleStrobe;
        // Stage a new sample; it lands once no read frame is open
        if (measured || testWrite) begin
            next_c.pendValid = 1'b1;
            next_c.pendMeasured = measured;
            next_c.pendCollide = c.busyS2 || (c.pendValid && c.pendCollide);
            if (measured) begin
                next_c.pend = meas;
                // Shake testing is off in test mode
                next_c.pendShake = (c.intSetup[msi_pkg::SHAKE_X_BIT] && overLimit(meas.x))
                    || (c.intSetup[msi_pkg::SHAKE_Y_BIT] && overLimit(meas.y))
                    || (c.intSetup[msi_pkg::SHAKE_Z_BIT] && overLimit(meas.z));
            end else begin
                next_c.pend.y = (l.wrAddr == msi_pkg::REG_Y) ? l.wrData[5:0] : c.y;
                next_c.pend.z = (l.wrAddr == msi_pkg::REG_Z) ? l.wrData[5:0] : c.z;
                next_c.pend.face = c.face;
                next_c.pend.port = c.port;
                next_c.pend.tap = 1'b0;
                next_c.pendShake = 1'b0;
            end
        end else if (c.pendValid && c.busyS2) begin
            next_c.pendCollide = 1'b1;
        end else if (c.pendValid) begin
            apply = 1'b1;
            next_c.pendValid = 1'b0;
        end
        // Commit the staged sample with its collision mark
        if (apply) begin
            newFace = cleanFace(c.pend.face);
            newPort = cleanPort(c.pend.port);
            if (c.firstSample && c.pendMeasured) begin
                // Flat unit reports face only, upright unit portrait only
                if (newFace != msi_pkg::FACE_UNKNOWN) begin
                    newPort = msi_pkg::PORT_UNKNOWN;
                end else begin
                    newFace = msi_pkg::FACE_UNKNOWN;
                end
                next_c.firstSample = 1'b0;
            end
            faceChg = newFace != c.face;
            portChg = newPort != c.port;
            next_c.y = c.pend.y;
            next_c.z = c.pend.z;
            next_c.alert = c.pendCollide;
            next_c.face = newFace;
            next_c.port = newPort;
            next_c.tap = c.pend.tap;
            next_c.pendCollide = 1'b0;
            activity = c.pendMeasured && (faceChg || portChg || c.pend.tap || c.pendShake);
        end
        // Status read clears shake, but a new shake in that cycle wins
        next_c.shake = (c.shake && !tiltRdEvt) || (apply && c.pendShake);
        // Auto-sleep counting; the every-sample event plays no part here
        if (!modeActive) begin
            next_c.inWake = 1'b0;
            next_c.sleepCount = msi_pkg::SLEEP_ZERO;
        end else if (activity) begin
            next_c.sleepCount = msi_pkg::SLEEP_ZERO;
            if (c.inWake && autoWakeEnable) begin
                next_c.inWake = 1'b0;
            end
        end else if (sleepTick && autoSleepEnable && !c.inWake && !wrEvt) begin
            if (c.sleepCount + 8'h01 == c.sleepLimit) begin
                next_c.inWake = 1'b1;
                next_c.sleepCount = msi_pkg::SLEEP_ZERO;
                sleepExit = 1'b1;
            end else begin
                next_c.sleepCount = c.sleepCount + 8'h01;
            end
        end
        if (modeActive && !c.prevActive) begin
            next_c.firstSample = 1'b1;
        end
        next_c.activeRateInUse = modeActive && !next_c.inWake;
        next_c.wakeRateInUse = modeActive && next_c.inWake;
        next_c.sampleRateCode = next_c.inWake ? {1'b0, wake_rate_field} : active_rate_field;
        // Interrupt sources, each behind its own enable
        irqEvt = (faceChg && c.intSetup[msi_pkg::FACE_EN_BIT])
            || (portChg && c.intSetup[msi_pkg::PORT_EN_BIT])
            || (apply && c.pend.tap && c.intSetup[msi_pkg::TAP_EN_BIT])
            || (sleepExit && c.intSetup[msi_pkg::SLEEP_EN_BIT])
            || (apply && c.intSetup[msi_pkg::EVERY_EN_BIT])
            || (apply && c.pendShake);
        // Address acknowledge releases; a fresh event in that cycle wins
        next_c.irqActive = (c.irqActive && !relEvt) || irqEvt;
        next_c.irqPin = irq_polarity_select ? next_c.irqActive : !next_c.irqActive;
        if (sys_rst) begin
            next_c = '0;
            next_c.irqPin = 1'b1; // Idle for the active-low default
        end
    end

    // Core register
    always_ff @(posedge clk) begin
        c <= next_c;
    end

    assign sdaOut = l.sdaOut;
    assign sdaOeN = l.sdaOeN;
    assign irqPin = c.irqPin;
    assign active_rate_in_use = c.activeRateInUse;
    assign wake_rate_in_use = c.wakeRateInUse;
    assign sampleRateCode = c.sampleRateCode;
endmodule
`default_nettype wire

/* verification/msi_host_model.sv */
// Serial host model that frames register reads and writes
`default_nettype none
module msi_host_model #(
    parameter logic [6:0] ADDR = 7'h2A
) (
    output logic sclClk,
    output logic sdaIn,
    input wire logic sdaOeN,
    input wire logic sdaOut
);
    timeunit 1ns;
    timeprecision 1ns;
    logic hostLow = 1'b0;
    initial sclClk = 1'b0;
    // Pulled-up line, low whenever either party pulls it
    assign sdaIn = !hostLow && (sdaOeN || sdaOut);
    // Data changes only while the clock is low
    task automatic put(input logic b);
        #20 hostLow = !b;
        #20 sclClk = 1'b1;
        #40 sclClk = 1'b0;
    endtask
    task automatic get(output logic b);
        #20 hostLow = 1'b0;
        #20 sclClk = 1'b1;
        #20 b = sdaIn;
        #20 sclClk = 1'b0;
    endtask
    // Clock runs only inside frames and while reset settles the link side
    task automatic tick(input int n);
        repeat (n) put(1'b1);
    endtask
    task automatic start();
        #20 hostLow = 1'b0;
        #20 sclClk = 1'b1;
        #20 hostLow = 1'b1;
        #20 sclClk = 1'b0;
    endtask
    task automatic tx(input logic [7:0] v, output logic nak);
        for (int i = 7; i >= 0; i--) put(v[i]);
        get(nak);
    endtask
    // Addressing the device also clears its interrupt
    task automatic wr(input logic [7:0] p, input logic [7:0] d, output logic nak);
        logic a, b, c;
        start();
        tx({ADDR, 1'b0}, a);
        tx(p, b);
        tx(d, c);
        nak = a | b | c;
    endtask
    task automatic rd(input logic [7:0] p, output logic [7:0] d, output logic nak);
        logic a, b, c;
        start();
        tx({ADDR, 1'b0}, a);
        tx(p, b);
        start();
        tx({ADDR, 1'b1}, c);
        for (int i = 7; i >= 0; i--) get(d[i]);
        put(1'b1);
        nak = a | b | c;
    endtask
endmodule
`default_nettype wire

/* verification/msi_status_regs_bench.sv */
// Self-checking bench for the motion status register bank
`default_nettype none
module msi_status_regs_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0;
    logic rst = 1'b0;
    logic act = 1'b0, tst = 1'b0, pol = 1'b0, ase = 1'b0, tick = 1'b0, stb = 1'b0, n;
    msi_pkg::msi_meas_t meas = '0;
    wire logic scl, sda, oeN, sdo, irq, ar, wk;
    wire logic [2:0] src;
    int fails = 0, nChecks = 0;
    always #10 clk = !clk;
    msi_host_model host (.sclClk(scl), .sdaIn(sda), .sdaOeN(oeN), .sdaOut(sdo));
    msi_status_regs dut (.clk(clk), .sys_rst(rst), .sclClk(scl), .sdaIn(sda), .sdaOut(sdo),
        .sdaOeN(oeN), .irqPin(irq), .modeActive(act), .test_mode_bit(tst),
        .irq_polarity_select(pol), .autoSleepEnable(ase), .autoWakeEnable(1'b0),
        .active_rate_field(3'h5), .wake_rate_field(2'h2), .sleepTick(tick),
        .sampleStrobe(stb), .meas(meas), .active_rate_in_use(ar), .wake_rate_in_use(wk),
        .sampleRateCode(src));
    task automatic chk(input string nm, input logic [8:0] e, input logic [8:0] g);
        nChecks++;
        if (g !== e) begin
            fails++;
            $display("FAIL %s expected %h seen %h", nm, e, g);
        end
    endtask
    // Read with acknowledge folded into bit 8
    task automatic rchk(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] d;
        host.rd(a, d, n);
        chk("reg", {1'b0, e}, {n, d});
    endtask
    task automatic step(input int c);
        repeat (c) @(posedge clk);
        #2;
    endtask
    // Idle first so no frame is still open when the pulse lands
    task automatic pulse(input logic s, input logic [23:0] m);
        step(5);
        meas = m;
        stb = s;
        tick = !s;
        step(1);
        stb = 1'b0;
        tick = 1'b0;
        step(4);
    endtask
    task automatic testDone();
        if (fails == 0 && nChecks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    initial begin
        #1000000;
        fails++;
        testDone();
    end
    // Writes stay in standby; samples and ticks only in active mode
    initial begin
        // Raise reset after time zero so the start detector sees a real edge
        #1 rst = 1'b1;
        host.tick(4);
        step(1);
        rst = 1'b0;
        host.tick(4);
        for (int a = 1; a < 8; a++) rchk(a[7:0], 8'h00);
        chk("irq", 9'h001, {8'h00, irq});
        host.wr(8'h05, 8'hAB, n);
        rchk(8'h05, 8'hAB);
        host.wr(8'h03, 8'h5A, n);
        rchk(8'h03, 8'h00);
        host.wr(8'h01, 8'h15, n);
        rchk(8'h01, 8'h00);
        tst = 1'b1;
        host.wr(8'h01, 8'h15, n);
        rchk(8'h01, 8'h15);
        tst = 1'b0;
        host.start();
        host.tx(8'h56, n);
        chk("nak", 9'h001, {8'h00, n});
        host.wr(8'h06, 8'h04, n);
        act = 1'b1;
        pulse(1'b1, {6'h00, 6'h3B, 6'h1F, 2'h1, 3'h1, 1'b1});
        chk("irq", 9'h000, {8'h00, irq});
        rchk(8'h01, 8'h3B);
        chk("irq", 9'h001, {8'h00, irq});
        rchk(8'h02, 8'h1F);
        rchk(8'h03, 8'h21);
        act = 1'b0;
        host.wr(8'h06, 8'h40, n);
        act = 1'b1;
        pulse(1'b1, {6'h00, 6'h25, 6'h1F, 2'h1, 3'h1, 1'b0});
        chk("irq", 9'h001, {8'h00, irq});
        rchk(8'h03, 8'h01);
        pulse(1'b1, {6'h00, 6'h24, 6'h1F, 2'h1, 3'h1, 1'b0});
        chk("irq", 9'h000, {8'h00, irq});
        rchk(8'h03, 8'h85);
        rchk(8'h03, 8'h05);
        act = 1'b0;
        host.wr(8'h05, 8'h03, n);
        host.wr(8'h06, 8'h08, n);
        pol = 1'b1;
        ase = 1'b1;
        act = 1'b1;
        pulse(1'b0, meas);
        pulse(1'b0, meas);
        rchk(8'h04, 8'h01);
        chk("irq", 9'h000, {8'h00, irq});
        pulse(1'b0, meas);
        chk("irq", 9'h001, {8'h00, irq});
        rchk(8'h04, 8'h02);
        chk("code", 9'h002, {6'h00, src});
        testDone();
    end
endmodule
`default_nettype wire

/* verification/msi_status_regs_checker.sv */
// Port assertions for the motion status register bank
`default_nettype none
module msi_status_regs_checker (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic irqPin,
    input wire logic irq_polarity_select,
    input wire logic modeActive,
    input wire logic autoSleepEnable,
    input wire logic sleepTick,
    input wire logic [2:0] active_rate_field,
    input wire logic [1:0] wake_rate_field,
    input wire logic active_rate_in_use,
    input wire logic wake_rate_in_use,
    input wire logic [2:0] sampleRateCode
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);
    // Rate flags are exclusive and follow the selected fields
    property p_rate_excl; !(active_rate_in_use && wake_rate_in_use); endproperty
    a_rate_excl: assert property (p_rate_excl) else $error("two rates in use");
    property p_entry; $rose(modeActive) |-> ##[1:3] active_rate_in_use; endproperty
    a_entry: assert property (p_entry) else $error("active rate not taken");
    property p_wcode; wake_rate_in_use && $past(wake_rate_in_use) && $stable(wake_rate_field)
        |-> sampleRateCode == {1'b0, wake_rate_field}; endproperty
    a_wcode: assert property (p_wcode) else $error("wake code wrong");
    property p_acode; active_rate_in_use && $past(active_rate_in_use)
        && $stable(active_rate_field) |-> sampleRateCode == active_rate_field; endproperty
    a_acode: assert property (p_acode) else $error("active code wrong");
    // Wake rate comes only from a counted tick in auto-sleep
    property p_wcause; $rose(wake_rate_in_use)
        |-> $past(sleepTick) || $past(sleepTick, 2) || $past(sleepTick, 3); endproperty
    a_wcause: assert property (p_wcause) else $error("wake without tick");
    property p_wgate; $rose(wake_rate_in_use) |-> $past(autoSleepEnable && modeActive);
    endproperty
    a_wgate: assert property (p_wgate) else $error("wake outside auto-sleep");
    // Pin level tracks the polarity select
    property p_pol; $changed(irq_polarity_select) |-> ##[1:2] $changed(irqPin); endproperty
    a_pol: assert property (p_pol) else $error("pin ignores polarity");
    property p_idle; $past(sys_rst) && !irq_polarity_select |-> irqPin; endproperty
    a_idle: assert property (p_idle) else $error("pin active after reset");
    c_wake: cover property ($rose(wake_rate_in_use));
    c_irq: cover property (irqPin == irq_polarity_select);
    c_entry: cover property ($rose(modeActive));
endmodule
bind msi_status_regs msi_status_regs_checker u_chk (.clk(clk), .sys_rst(sys_rst),
    .irqPin(irqPin), .irq_polarity_select(irq_polarity_select), .modeActive(modeActive),
    .autoSleepEnable(autoSleepEnable), .sleepTick(sleepTick),
    .active_rate_field(active_rate_field), .wake_rate_field(wake_rate_field),
    .active_rate_in_use(active_rate_in_use), .wake_rate_in_use(wake_rate_in_use),
    .sampleRateCode(sampleRateCode));
`default_nettype wire
